// >>> include/sbtf_defs.svh
// register offsets, field positions, reset values and sizes of the spi unit
`ifndef SBTF_DEFS_SVH
`define SBTF_DEFS_SVH

// ============================================================
// register byte addresses
`define SBTF_ADDR_W 8
`define SBTF_OFS_CTRL1 8'h00
`define SBTF_OFS_CTRL2 8'h04
`define SBTF_OFS_BAUD 8'h08
`define SBTF_OFS_STATUS 8'h0C
`define SBTF_OFS_DATA 8'h14

// ============================================================
// control_register_one fields
`define SBTF_C1_GIE 7
`define SBTF_C1_SPE 6
`define SBTF_C1_TIE 5
`define SBTF_C1_MASTER_SELECT 4
`define SBTF_C1_CPOL 3
`define SBTF_C1_CLOCK_PHASE 2
`define SBTF_C1_SELECT_OUTPUT_ENABLE 1
`define SBTF_C1_LSB 0

// control two fields
`define SBTF_C2_FEN 4
`define SBTF_C2_BIDIR 0

// serial_status fields
`define SBTF_ST_RXF 7
`define SBTF_ST_TXE 5
`define SBTF_ST_MODE_FAULT_FLAG 4

// ============================================================
// reset values and counts
`define SBTF_CTRL1_RST 8'h04
`define SBTF_CTRL2_RST 8'h00
`define SBTF_BAUD_RST 8'h00
`define SBTF_DATA_RST 8'h00
`define SBTF_LAST_EDGE 4'hF
`define SBTF_RESP_OKAY 2'h0
`define SBTF_RESP_SLVERR 2'h2

`endif

// >>> include/sbtf_pkg.sv
// types shared by the spi unit and its bench
package sbtf_pkg;

    // ============================================================
    // axi4-lite request from the master
    typedef struct packed {
        logic awvalid;
        logic [7:0] awaddr;
        logic wvalid;
        logic [31:0] wdata;
        logic [3:0] wstrb;
        logic bready;
        logic arvalid;
        logic [7:0] araddr;
        logic rready;
    } sbtf_axi_req_t;

    // axi4-lite answer from the slave
    typedef struct packed {
        logic awready;
        logic wready;
        logic bvalid;
        logic [1:0] bresp;
        logic arready;
        logic rvalid;
        logic [31:0] rdata;
        logic [1:0] rresp;
    } sbtf_axi_rsp_t;

    // ============================================================
    // serial pins as seen by the unit
    typedef struct packed {
        logic sck;
        logic mosi;
        logic miso;
        logic ss_n;
    } sbtf_pin_in_t;

    // output enables are active low
    typedef struct packed {
        logic sck;
        logic sck_oe_n;
        logic mosi;
        logic mosi_oe_n;
        logic miso;
        logic miso_oe_n;
        logic ss_n;
        logic ss_oe_n;
    } sbtf_pin_out_t;

    // ============================================================
    // whole state of the unit
    typedef struct packed {
        logic [2:0] sck_s, ss_s, mi_s, mo_s;
        logic sck_f, ss_f, mi_f, mo_f;
        logic [7:0] ctrl1, ctrl2, baud;
        logic [7:0] tx_buf, rx_buf, shifter;
        logic tx_full, rx_full, mode_fault;
        logic tx_armed, rx_armed, mf_armed;
        logic busy;
        logic [3:0] edge_idx;
        logic sbit;
        logic [7:0] div;
        logic sck_out, ss_out, dout;
        logic sck_oe_n, mosi_oe_n, miso_oe_n, ss_oe_n;
        logic aw_have, w_have, wen;
        logic [7:0] awaddr, wdata;
        logic bvalid;
        logic [1:0] bresp;
        logic rvalid;
        logic [31:0] rdata;
        logic [1:0] rresp;
    } sbtf_state_t;

endpackage

// >>> hdl/sbtf_core.sv
// buffered spi data path, status flags and axi4-lite register slave
//
// Summary of operation
// - transfer end sets receive-full flag, status bit 7.
// - receive-full clears on status read with flag set, then data read.
// - transmit-empty, bit 5, set when buffer free; status read then write.
// - data write ignored unless status read first showed transmit-empty.
// - transmit-empty with transmit interrupt enable raises interrupt.
// - idle master moves written byte to shifter in the write cycle; flag stays set.
// - shift done, nothing queued: flag stays set, shifter not loaded.
// - mode fault on low select in master, fault enable 1, select out 0.
// - mode fault clears on status read showing it, then control one write.
// - status bits 6,3,2,1,0 read zero; status writes do nothing.
// - data read gives receive buffer, write loads transmit; reset zero.
// - master mode: queued byte starts transfer once shifter free.
// - free shifter takes queued byte, sets transmit-empty, starts shifting.
// - sample on one edge, shift half period later; eight clock cycles.
// - transfer end fills receive buffer; queued byte then starts next.
// - msb first by default, lsb first when bit order select set.
// - transmit and receive paths each double buffered.
// - unread receive buffer: new byte discarded, no overrun indication.
// - receive-full or mode fault with general enable raises interrupt.
// - mode fault drops master mode, disables clock driver and, unless bidirectional, data drivers.
`timescale 1ns/1ps
`include "sbtf_defs.svh"

module sbtf_core (
    // clock and reset
    input wire logic i_mclk,
    input wire logic i_rst,
    // axi4-lite register bus
    input wire sbtf_pkg::sbtf_axi_req_t i_axi,
    output sbtf_pkg::sbtf_axi_rsp_t o_axi,
    // serial pins
    input wire sbtf_pkg::sbtf_pin_in_t i_pin,
    output sbtf_pkg::sbtf_pin_out_t o_pin,
    // interrupt request
    output logic o_irq
);
    import sbtf_pkg::*;

    sbtf_state_t s;
    sbtf_state_t next_s;
    logic aw_hs, w_hs, ar_hs;
    logic spe, master_select, clock_phase, lsb, cpol, fen, select_output_enable, bidir;
    logic sck_edge, ss_fall, ss_rise, ev, sin, mf_cond;
    logic [7:0] rx_byte;

    // shift one bit in at the end opposite to the outgoing bit
    function automatic logic [7:0] shin(input logic [7:0] sh,
                                        input logic b, input logic lf);
        return lf ? {b, sh[7:1]} : {sh[6:0], b};
    endfunction

    // ============================================================
    // bus handshakes and control decode
    assign aw_hs = i_axi.awvalid & ~s.aw_have & ~s.bvalid;
    assign w_hs = i_axi.wvalid & ~s.w_have & ~s.bvalid;
    assign ar_hs = i_axi.arvalid & ~s.rvalid;
    assign o_axi.awready = ~s.aw_have & ~s.bvalid;
    assign o_axi.wready = ~s.w_have & ~s.bvalid;
    assign o_axi.bvalid = s.bvalid;
    assign o_axi.bresp = s.bresp;
    assign o_axi.arready = ~s.rvalid;
    assign o_axi.rvalid = s.rvalid;
    assign o_axi.rdata = s.rdata;
    assign o_axi.rresp = s.rresp;

    // interrupt is a level straight from the flags
    assign o_irq = (s.ctrl1[`SBTF_C1_GIE] & (s.rx_full | s.mode_fault))
                 | (s.ctrl1[`SBTF_C1_TIE] & ~s.tx_full);

    // pins come from flops only
    assign o_pin.sck = s.sck_out;
    assign o_pin.sck_oe_n = s.sck_oe_n;
    assign o_pin.mosi = s.dout;
    assign o_pin.mosi_oe_n = s.mosi_oe_n;
    assign o_pin.miso = s.dout;
    assign o_pin.miso_oe_n = s.miso_oe_n;
    assign o_pin.ss_n = s.ss_out;
    assign o_pin.ss_oe_n = s.ss_oe_n;

    // filtered pin edges: second and third stage must agree
    assign sck_edge = (s.sck_s[1] == s.sck_s[2]) & (s.sck_s[2] != s.sck_f);
    assign ss_fall = (s.ss_s[1] == s.ss_s[2]) & s.ss_f & ~s.ss_s[2];
    assign ss_rise = (s.ss_s[1] == s.ss_s[2]) & ~s.ss_f & s.ss_s[2];

    // ============================================================
    // next state
    always_comb begin
        next_s = s;
        // three-stage synchronisers and agreement filters
        next_s.sck_s = {s.sck_s[1:0], i_pin.sck};
        next_s.ss_s = {s.ss_s[1:0], i_pin.ss_n};
        next_s.mi_s = {s.mi_s[1:0], i_pin.miso};
        next_s.mo_s = {s.mo_s[1:0], i_pin.mosi};
        if (s.sck_s[1] == s.sck_s[2]) begin
            next_s.sck_f = s.sck_s[2];
        end
        if (s.ss_s[1] == s.ss_s[2]) begin
            next_s.ss_f = s.ss_s[2];
        end
        if (s.mi_s[1] == s.mi_s[2]) begin
            next_s.mi_f = s.mi_s[2];
        end
        if (s.mo_s[1] == s.mo_s[2]) begin
            next_s.mo_f = s.mo_s[2];
        end

        // write address and data are taken in either order
        if (aw_hs) begin
            next_s.aw_have = 1'b1;
            next_s.awaddr = i_axi.awaddr;
        end
        if (w_hs) begin
            next_s.w_have = 1'b1;
            next_s.wdata = i_axi.wdata[7:0];
            next_s.wen = i_axi.wstrb[0];
        end
        if (s.bvalid & i_axi.bready) begin
            next_s.bvalid = 1'b0;
        end
        if (s.rvalid & i_axi.rready) begin
            next_s.rvalid = 1'b0;
        end

        // register write, once both halves are present
        if (next_s.aw_have & next_s.w_have & ~s.bvalid) begin
            next_s.aw_have = 1'b0;
            next_s.w_have = 1'b0;
            next_s.bvalid = 1'b1;
            next_s.bresp = `SBTF_RESP_OKAY;
            if (next_s.awaddr == `SBTF_OFS_CTRL1) begin
                if (next_s.wen) begin
                    next_s.ctrl1 = next_s.wdata;
                end
                if (s.mf_armed) begin
                    next_s.mode_fault = 1'b0;
                end
                next_s.mf_armed = 1'b0;
            end else if (next_s.awaddr == `SBTF_OFS_CTRL2) begin
                if (next_s.wen) begin
                    next_s.ctrl2 = next_s.wdata;
                end
            end else if (next_s.awaddr == `SBTF_OFS_BAUD) begin
                if (next_s.wen) begin
                    next_s.baud = next_s.wdata;
                end
            end else if (next_s.awaddr == `SBTF_OFS_STATUS) begin
                next_s.bresp = `SBTF_RESP_OKAY;
            end else if (next_s.awaddr == `SBTF_OFS_DATA) begin
                // unarmed writes are dropped silently
                if (s.tx_armed & ~s.tx_full & next_s.wen) begin
                    next_s.tx_buf = next_s.wdata;
                    next_s.tx_full = 1'b1;
                end
                next_s.tx_armed = 1'b0;
            end else begin
                next_s.bresp = `SBTF_RESP_SLVERR;
            end
        end

        // register read with its side effects
        if (ar_hs) begin
            next_s.rvalid = 1'b1;
            next_s.rresp = `SBTF_RESP_OKAY;
            next_s.rdata = 32'h0000_0000;
            if (i_axi.araddr == `SBTF_OFS_CTRL1) begin
                next_s.rdata[7:0] = s.ctrl1;
            end else if (i_axi.araddr == `SBTF_OFS_CTRL2) begin
                next_s.rdata[7:0] = s.ctrl2;
            end else if (i_axi.araddr == `SBTF_OFS_BAUD) begin
                next_s.rdata[7:0] = s.baud;
            end else if (i_axi.araddr == `SBTF_OFS_STATUS) begin
                // unused bits stay zero
                next_s.rdata[`SBTF_ST_RXF] = s.rx_full;
                next_s.rdata[`SBTF_ST_TXE] = ~s.tx_full;
                next_s.rdata[`SBTF_ST_MODE_FAULT_FLAG] = s.mode_fault;
                next_s.rx_armed = s.rx_full;
                next_s.tx_armed = ~s.tx_full;
                next_s.mf_armed = s.mode_fault;
            end else if (i_axi.araddr == `SBTF_OFS_DATA) begin
                next_s.rdata[7:0] = s.rx_buf;
                if (s.rx_armed) begin
                    next_s.rx_full = 1'b0;
                end
                next_s.rx_armed = 1'b0;
            end else begin
                next_s.rresp = `SBTF_RESP_SLVERR;
            end
        end

        // control fields after any write this cycle
        spe = next_s.ctrl1[`SBTF_C1_SPE];
        clock_phase = next_s.ctrl1[`SBTF_C1_CLOCK_PHASE];
        cpol = next_s.ctrl1[`SBTF_C1_CPOL];
        lsb = next_s.ctrl1[`SBTF_C1_LSB];
        select_output_enable = next_s.ctrl1[`SBTF_C1_SELECT_OUTPUT_ENABLE];
        fen = next_s.ctrl2[`SBTF_C2_FEN];
        bidir = next_s.ctrl2[`SBTF_C2_BIDIR];

        // mode fault: set wins over a clear in the same cycle
        mf_cond = spe & s.ctrl1[`SBTF_C1_MASTER_SELECT] & fen & ~select_output_enable & ~s.ss_f;
        if (mf_cond) begin
            next_s.mode_fault = 1'b1;
            next_s.ctrl1[`SBTF_C1_MASTER_SELECT] = 1'b0;
            next_s.busy = 1'b0;
        end
        master_select = next_s.ctrl1[`SBTF_C1_MASTER_SELECT];

        // serial edge source: own divider as master, pin as slave
        ev = 1'b0;
        if (master_select & s.busy) begin
            ev = (s.div == 8'h00);
            next_s.div = ev ? s.baud : s.div - 8'h01;
        end else if (~master_select & s.busy) begin
            ev = sck_edge;
        end
        sin = master_select ? s.mi_f : s.mo_f;
        rx_byte = shin(s.shifter, clock_phase ? sin : s.sbit, lsb);

        // sample on one edge, shift on the next
        if (ev & next_s.busy & spe) begin
            next_s.sck_out = ~s.sck_out;
            if (s.edge_idx[0] == clock_phase) begin
                next_s.sbit = sin;
            end else if (~(clock_phase & (s.edge_idx == 4'h0))) begin
                next_s.shifter = shin(s.shifter, s.sbit, lsb);
            end
            if (s.edge_idx == `SBTF_LAST_EDGE) begin
                // a full receive buffer loses the new byte quietly
                if (~next_s.rx_full) begin
                    next_s.rx_buf = rx_byte;
                    next_s.rx_full = 1'b1;
                end
                next_s.shifter = rx_byte;
                next_s.edge_idx = 4'h0;
                // slave in phase 1 may run on while select stays low
                next_s.busy = ~master_select & clock_phase & ~s.ss_f;
                if (next_s.busy & next_s.tx_full) begin
                    next_s.shifter = next_s.tx_buf;
                    next_s.tx_full = 1'b0;
                end
            end else begin
                next_s.edge_idx = s.edge_idx + 4'h1;
            end
        end

        // master start: shifter free and a byte queued
        if (spe & master_select & ~next_s.busy & next_s.tx_full) begin
            next_s.shifter = next_s.tx_buf;
            next_s.tx_full = 1'b0;
            next_s.busy = 1'b1;
            next_s.edge_idx = 4'h0;
            next_s.div = s.baud;
            next_s.sck_out = cpol;
        end

        // slave start and abort follow the select line
        if (spe & ~master_select & ss_fall & ~s.busy) begin
            next_s.busy = 1'b1;
            next_s.edge_idx = 4'h0;
            if (next_s.tx_full) begin
                next_s.shifter = next_s.tx_buf;
                next_s.tx_full = 1'b0;
            end
        end
        if (~master_select & ss_rise) begin
            next_s.busy = 1'b0;
        end
        if (~spe) begin
            next_s.busy = 1'b0;
        end
        if (~master_select | ~next_s.busy) begin
            next_s.sck_out = cpol;
        end

        // pin drivers; fault keeps the data pin drivers only when bidirectional
        next_s.dout = lsb ? next_s.shifter[0] : next_s.shifter[7];
        next_s.sck_oe_n = ~(spe & master_select);
        next_s.mosi_oe_n = ~(spe & (master_select | (bidir & next_s.mode_fault)));
        next_s.miso_oe_n = ~(spe & ~master_select & ~next_s.ss_f
                             & (bidir | ~next_s.mode_fault));
        next_s.ss_oe_n = ~(spe & master_select & fen & select_output_enable);
        next_s.ss_out = ~(master_select & next_s.busy);
    end

    // ============================================================
    // state register; select synchroniser starts deselected
    always_ff @(posedge i_mclk or posedge i_rst) begin
        if (i_rst) begin
            s <= '0;
            s.ss_s <= 3'h7;
            s.ss_f <= 1'b1;
            s.ctrl1 <= `SBTF_CTRL1_RST;
            s.ctrl2 <= `SBTF_CTRL2_RST;
            s.baud <= `SBTF_BAUD_RST;
            s.tx_buf <= `SBTF_DATA_RST;
            s.rx_buf <= `SBTF_DATA_RST;
            s.ss_out <= 1'b1;
            s.sck_oe_n <= 1'b1;
            s.mosi_oe_n <= 1'b1;
            s.miso_oe_n <= 1'b1;
            s.ss_oe_n <= 1'b1;
        end else begin
            s <= next_s;
        end
    end

endmodule

// >>> verification/sbtf_slave_model.sv
// behavioural remote slave on the serial side, phase 0, idle-low clock
`timescale 1ns/1ps

module sbtf_slave_model (
    // serial pins from the unit
    input wire logic i_sck,
    input wire logic i_mosi,
    input wire logic i_ss_n,
    // bit order and first reply byte
    input wire logic i_lsb,
    input wire logic [7:0] i_tx,
    // reply line and last byte taken in
    output logic o_miso,
    output logic [7:0] o_rx
);
    int k;
    int nb;

    // each reply byte is the first one plus its index, so overruns show
    function automatic logic bitv();
        logic [7:0] b;
        b = i_tx + 8'(nb);
        return i_lsb ? b[k] : b[7-k];
    endfunction

    initial begin
        k = 0;
        nb = 0;
        o_miso = 1'b0;
        o_rx = 8'h00;
    end

    // first bit goes out as soon as the slave is selected
    always @(negedge i_ss_n) begin
        k = 0;
        o_miso = bitv();
    end

    // sample on the rising edge
    always @(posedge i_sck) begin
        if (!i_ss_n) begin
            o_rx = i_lsb ? {i_mosi, o_rx[7:1]} : {o_rx[6:0], i_mosi};
        end
    end

    // change half a period later; a queued byte follows with no gap;
    // no select test: the last clock fall and the select rise share a step
    always @(negedge i_sck) begin
        k = k + 1;
        if (k == 8) begin
            k = 0;
            nb = nb + 1;
        end
        o_miso = bitv();
    end

    // deselected line floats: show the opposite of the last bit
    always @(posedge i_ss_n) begin
        o_miso = ~o_miso;
    end
endmodule

// >>> verification/sbtf_core_properties.sv
// port-level assertion checker for the spi unit
`timescale 1ns/1ps
`include "sbtf_defs.svh"

module sbtf_core_properties (
    // clock and reset
    input wire logic i_mclk,
    input wire logic i_rst,
    // observed ports
    input wire sbtf_pkg::sbtf_axi_req_t i_axi,
    input wire sbtf_pkg::sbtf_axi_rsp_t o_axi,
    input wire sbtf_pkg::sbtf_pin_in_t i_pin,
    input wire sbtf_pkg::sbtf_pin_out_t o_pin,
    input wire logic o_irq
);
    import sbtf_pkg::*;
    default clocking cb @(posedge i_mclk); endclocking
    default disable iff (i_rst);

    // ============================================================
    // helpers: last read address, clock rises per select frame
    logic [7:0] last_ar;
    logic [5:0] rises;
    logic sck_q;
    logic ss_q;
    always_ff @(posedge i_mclk or posedge i_rst) begin
        if (i_rst) begin
            last_ar <= 8'h00;
            rises <= 6'h00;
            sck_q <= 1'b0;
            ss_q <= 1'b1;
        end else begin
            sck_q <= o_pin.sck;
            ss_q <= o_pin.ss_n;
            if (i_axi.arvalid && o_axi.arready) last_ar <= i_axi.araddr;
            if (!o_pin.ss_n && ss_q) rises <= 6'h00;
            else if (o_pin.sck && !sck_q) rises <= rises + 6'h01;
        end
    end

    // ============================================================
    // bus handshakes
    sequence s_write_taken;
        i_axi.awvalid && o_axi.awready && i_axi.wvalid && o_axi.wready;
    endsequence
    sequence s_read_taken;
        i_axi.arvalid && o_axi.arready;
    endsequence

    a_write_answer: assert property (s_write_taken |=> o_axi.bvalid
        && !o_axi.awready && !o_axi.wready) else $error("write not answered");
    a_read_answer: assert property (s_read_taken |=> o_axi.rvalid
        && !o_axi.arready) else $error("read not answered");
    a_read_holds: assert property (o_axi.rvalid && !i_axi.rready |=>
        o_axi.rvalid && $stable(o_axi.rdata)) else $error("read data moved");
    a_write_holds: assert property (o_axi.bvalid && !i_axi.bready |=>
        o_axi.bvalid && $stable(o_axi.bresp)) else $error("response moved");
    a_status_zeros: assert property (o_axi.rvalid &&
        last_ar == `SBTF_OFS_STATUS |-> o_axi.rdata[6] == 1'b0 &&
        o_axi.rdata[3:0] == 4'h0 && o_axi.rdata[31:8] == 24'h000000)
        else $error("status spare bits set");
    a_unmapped_err: assert property (o_axi.rvalid && !(last_ar inside
        {8'h00, 8'h04, 8'h08, 8'h0C, 8'h14}) |->
        o_axi.rresp == `SBTF_RESP_SLVERR) else $error("unmapped read okay");

    // ============================================================
    // serial framing
    a_frame_bits: assert property (o_pin.ss_n && !ss_q &&
        !o_pin.ss_oe_n |-> rises != 6'h00 && rises[2:0] == 3'h0)
        else $error("frame not whole bytes");
    a_sck_framed: assert property (o_pin.ss_n && !o_pin.ss_oe_n |->
        !(o_pin.sck && !sck_q)) else $error("clock outside frame");
    a_sample_stable: assert property ($rose(o_pin.sck) &&
        !o_pin.ss_n |-> $stable(o_pin.mosi)) else $error("data moved at sample");
endmodule

bind sbtf_core sbtf_core_properties u_props (.i_mclk(i_mclk), .i_rst(i_rst),
    .i_axi(i_axi), .o_axi(o_axi), .i_pin(i_pin), .o_pin(o_pin), .o_irq(o_irq));

// >>> verification/sbtf_core_test.sv
// self-checking bench for the spi unit as bus master and as bus slave
`timescale 1ns/1ps
`include "sbtf_defs.svh"

module sbtf_core_test;
    import sbtf_pkg::*;
    localparam logic [7:0] c1_a = `SBTF_OFS_CTRL1;
    localparam logic [7:0] st_a = `SBTF_OFS_STATUS;
    localparam logic [7:0] dt_a = `SBTF_OFS_DATA;
    logic i_mclk, i_rst, ss_in, lsb, miso, irq, sck_in, mosi_in;
    logic [7:0] slave_rx;
    logic [7:0] sl_got;
    logic [31:0] d;
    logic [1:0] r;
    sbtf_axi_req_t rq;
    sbtf_axi_rsp_t rs;
    sbtf_pin_out_t po;
    int mismatches, tests_run, cycles;

    // ============================================================
    // unit and remote slave; the bench plays remote master in slave mode
    sbtf_core dut (.i_mclk(i_mclk), .i_rst(i_rst), .i_axi(rq), .o_axi(rs),
        .i_pin({sck_in, mosi_in, miso, ss_in}), .o_pin(po), .o_irq(irq));
    sbtf_slave_model slave (.i_sck(po.sck), .i_mosi(po.mosi),
        .i_ss_n(po.ss_n), .i_lsb(lsb), .i_tx(8'h5A), .o_miso(miso),
        .o_rx(slave_rx));

    initial begin
        i_mclk = 1'b0;
        forever #5 i_mclk = ~i_mclk;
    end

    // hang guard, a few thousand cycles are plenty
    always @(posedge i_mclk) begin
        cycles++;
        if (cycles == 20000) begin
            mismatches++;
            stop_test();
        end
    end

    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        tests_run++;
        if (g !== e) begin
            mismatches++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask

    // bready is left to the caller, so only the two valids are released on taking
    task automatic wr(input logic [7:0] a, input logic [7:0] v);
        logic ta, tw, tb;
        rq.awvalid <= 1'b1;
        rq.awaddr <= a;
        rq.wvalid <= 1'b1;
        rq.wdata <= {24'h000000, v};
        tb = 1'b0;
        while (!tb) begin
            @(negedge i_mclk);
            ta = rq.awvalid && rs.awready;
            tw = rq.wvalid && rs.wready;
            tb = rs.bvalid;
            r = rs.bresp;
            @(posedge i_mclk);
            if (ta) rq.awvalid <= 1'b0;
            if (tw) rq.wvalid <= 1'b0;
        end
    endtask

    task automatic rd(input logic [7:0] a);
        logic ta, tr;
        rq.arvalid <= 1'b1;
        rq.araddr <= a;
        tr = 1'b0;
        while (!tr) begin
            @(negedge i_mclk);
            ta = rq.arvalid && rs.arready;
            tr = rs.rvalid;
            d = rs.rdata;
            r = rs.rresp;
            @(posedge i_mclk);
            if (ta) rq.arvalid <= 1'b0;
        end
    endtask

    task automatic rdc(input logic [7:0] a, input logic [31:0] e);
        rd(a);
        chk(d, e);
    endtask

    // a queued byte keeps select low, so one rise ends the burst
    task automatic wait_end();
        wait (po.ss_n === 1'b0);
        wait (po.ss_n === 1'b1);
        @(posedge i_mclk);
    endtask

    // remote master, phase 0, msb first, 80 ns clock; the unit needs
    // about four clocks to see an edge, so its bit is read at the fall
    task automatic sl_xfer(input logic [7:0] v);
        sl_got = 8'h00;
        mosi_in <= v[7];
        ss_in <= 1'b0;
        repeat (8) @(posedge i_mclk);
        for (int i = 7; i >= 0; i--) begin
            mosi_in <= v[i];
            repeat (4) @(posedge i_mclk);
            sck_in <= 1'b1;
            repeat (4) @(posedge i_mclk);
            sl_got = {sl_got[6:0], po.miso};
            sck_in <= 1'b0;
        end
        repeat (8) @(posedge i_mclk);
        ss_in <= 1'b1;
        repeat (8) @(posedge i_mclk);
    endtask

    task automatic stop_test();
        $display("comparisons %0d mismatches %0d", tests_run, mismatches);
        if (mismatches == 0 && tests_run > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    // ============================================================
    // main sequence
    initial begin
        rq = '0;
        rq.bready = 1'b1;
        rq.rready = 1'b1;
        rq.wstrb = 4'hF;
        i_rst = 1'b1;
        ss_in = 1'b1;
        sck_in = 1'b0;
        mosi_in = 1'b0;
        lsb = 1'b0;
        repeat (4) @(posedge i_mclk);
        i_rst <= 1'b0;
        // reset values, read-only status, unmapped place
        rdc(st_a, 32'h20);
        rdc(dt_a, 32'h00);
        wr(st_a, 8'hFF);
        rdc(st_a, 32'h20);
        rd(8'h10);
        chk(r, `SBTF_RESP_SLVERR);
        // master, phase 0, msb first, select output driven
        wr(`SBTF_OFS_CTRL2, 8'h10);
        wr(`SBTF_OFS_BAUD, 8'h07);
        wr(c1_a, 8'h72);
        chk(irq, 1'b1);
        // response held back a cycle so it must stand
        rq.bready <= 1'b0;
        wr(c1_a, 8'h52);
        rq.bready <= 1'b1;
        chk(irq, 1'b0);
        // second write without a fresh status read is dropped
        rd(st_a);
        wr(dt_a, 8'hA5);
        wr(dt_a, 8'h3C);
        wait_end();
        chk(slave_rx, 8'hA5);
        rdc(st_a, 32'hA0);
        rdc(dt_a, 32'h5A);
        rdc(st_a, 32'h20);
        // back to back; the second reply overruns the unread buffer
        rd(st_a);
        wr(dt_a, 8'h11);
        rdc(st_a, 32'h20);
        wr(dt_a, 8'h22);
        rdc(st_a, 32'h00);
        wait_end();
        chk(slave_rx, 8'h22);
        rdc(st_a, 32'hA0);
        rdc(dt_a, 32'h5B);
        // lsb first
        lsb <= 1'b1;
        wr(c1_a, 8'h53);
        rd(st_a);
        wr(dt_a, 8'h1E);
        wait_end();
        chk(slave_rx, 8'h1E);
        rdc(st_a, 32'hA0);
        rdc(dt_a, 32'h5D);
        // low select is no fault while select output is on
        ss_in <= 1'b0;
        repeat (8) @(posedge i_mclk);
        rdc(st_a, 32'h20);
        wr(c1_a, 8'hD0);
        repeat (8) @(posedge i_mclk);
        rdc(st_a, 32'h30);
        chk(irq, 1'b1);
        chk({po.sck_oe_n, po.mosi_oe_n}, 2'h3);
        rq.rready <= 1'b0;
        rdc(c1_a, 32'hC0);
        rq.rready <= 1'b1;
        ss_in <= 1'b1;
        repeat (8) @(posedge i_mclk);
        rd(st_a);
        wr(c1_a, 8'h40);
        rdc(st_a, 32'h20);
        // slave mode: queued byte goes out, remote byte comes in
        wr(dt_a, 8'hC3);
        rdc(st_a, 32'h00);
        sl_xfer(8'h96);
        chk(sl_got, 32'hC3);
        rdc(st_a, 32'hA0);
        rdc(dt_a, 32'h96);
        stop_test();
    end
endmodule
